// ### src/ecs_pkg.sv
package ecs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port layout.
  localparam int         REG_AW     = 5;
  localparam logic [4:0] OFS_SEL0   = 5'h00;
  localparam logic [4:0] OFS_SEL1   = 5'h04;
  localparam logic [4:0] OFS_SEL2   = 5'h08;
  localparam logic [4:0] OFS_SEL3   = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside select_window_control.
  localparam int BIT_PRIV_ONLY    = 15;
  localparam int BIT_READ_ONLY    = 14;
  localparam int BIT_PORT_WIDTH   = 13;
  localparam int BIT_WRITE_EXTRA  = 12;
  localparam int BIT_STROBE_STYLE = 11;
  localparam int BIT_WAIT_HI      = 10;
  localparam int BIT_WAIT_LO      = 8;
  localparam int BIT_INT_ACK      = 1;
  localparam int BIT_SEL_EN       = 0;

  localparam logic [15:0] CTRL_RESET = 16'h3F02;
  localparam logic [15:0] CTRL_WMASK = 16'hFF03;

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding and cycle constants.
  localparam int         ADDR_EXT_BIT  = 31;
  localparam int         WIN_HI        = 24;
  localparam int         WIN_LO        = 23;
  localparam int         HALF_ADDR_BIT = 1;
  localparam logic [1:0] SZ_WORD       = 2'h2;
  localparam int         CNT_W         = 4;
  localparam logic [3:0] CNT_ONE       = 4'h1;
  localparam logic [3:0] STROBE_IDLE   = 4'hF;

  typedef enum logic {ECS_IDLE, ECS_ACCESS} ecs_phase_t;

  function automatic logic [1:0] ecs_window(input logic [31:0] a);
    return a[WIN_HI:WIN_LO];
  endfunction

endpackage

// ### src/ecs_top.sv
// Behaviour
// - read-only window ignores writes
// - port width bit; narrow port on D31..16
// - word to narrow port runs two cycles
// - extra write wait adds one, writes only
// - strobe style: reads and writes, or writes
// - strobe style only while select active
// - one clock per wait state
// - wait field gives zero to seven, plus one
// - no internal ack: external ack ends cycle
// - external ack or error ends cycle early
// - disabled select holds output high
// - internal termination needs enable and ack
// - no match, no select, no termination
// - one active select governs the access
// - waits matter only with internal ack
// - address bit 31 marks external access
// - decode A31 and A24..23 only
// - selects 0..3 by A24..23 externally
// - no interrupt request ever
// - emulation moves select 1 to internal block
// - privileged-only window ignores user accesses
//
// Strobed register access and the register offsets were chosen for this implementation.
module ecs_top (
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic [4:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  input  wire logic        STRAP_BOOT_EN,
  input  wire logic        STRAP_BOOT_WIDE,
  input  wire logic        INTERNAL_MEM_EMULATION,
  input  wire logic        BUS_START,
  input  wire logic [31:0] BUS_ADDR,
  input  wire logic        BUS_RNW,
  input  wire logic [1:0]  BUS_SIZE,
  input  wire logic [3:0]  BUS_BE,
  input  wire logic        BUS_SUPERVISOR,
  input  wire logic [31:0] BUS_WDATA,
  output logic      [31:0] BUS_RDATA,
  output logic             BUS_DONE,
  output logic             BUS_ERR,
  output logic      [3:0]  CS_N,
  output logic      [3:0]  BYTE_STROBE_N,
  output logic      [31:0] EXT_ADDR,
  output logic      [31:0] EXT_DATA_OUT,
  output logic             EXT_DATA_OE_N,
  input  wire logic [31:0] EXT_DATA_IN,
  input  wire logic        TRANSFER_ACK_N,
  input  wire logic        TRANSFER_ERROR_ACK_N
);

  typedef struct packed {
    ecs_pkg::ecs_phase_t       state;
    logic [3:0][15:0]          ctrl;
    logic                      boot_seen;
    logic [1:0]                sel;
    logic                      narrow;
    logic                      dual;
    logic                      lo;
    logic                      write;
    logic                      int_ack;
    logic                      wr_strobe;
    logic [ecs_pkg::CNT_W-1:0] waits;
    logic [3:0]                be;
    logic [31:0]               wdata;
    logic [31:0]               rdata;
    logic [3:0]                cs_n;
    logic [3:0]                bs_n;
    logic [31:0]               addr;
    logic [31:0]               dout;
    logic                      doe_n;
    logic                      done;
    logic                      err;
    logic [15:0]               rd;
  } ecs_state_t;

  ecs_state_t  r;
  ecs_state_t  n;
  logic [3:0]  hit;
  logic [1:0]  sel_i;
  logic [1:0]  bus_win;
  logic [15:0] sel_ctrl;
  logic        addr_ok;
  logic        start_ok;
  logic        restart;
  logic        timer_expired;
  logic        term_int;
  logic        term;
  logic        single_cyc;

  ////////////////////////////////////////////////////////////////////////////
  // Lane steering. A narrow port only ever sees the upper two lanes.
  function automatic logic [3:0] lane_strobes(input logic [3:0] be, input logic narrow,
                                              input logic lo, input logic show);
    logic [3:0] s;
    s = narrow ? {(lo ? be[1:0] : be[3:2]), 2'h0} : be;
    return show ? ~s : ecs_pkg::STROBE_IDLE;
  endfunction

  function automatic logic [31:0] lane_data(input logic [31:0] wd, input logic narrow, input logic lo);
    return narrow ? {(lo ? wd[15:0] : wd[31:16]), 16'h0000} : wd;
  endfunction

  function automatic logic [31:0] lane_capture(input logic [31:0] old, input logic [31:0] din,
                                               input logic narrow, input logic lo);
    logic [31:0] v;
    v = din;
    if (narrow) begin
      v = lo ? {old[31:16], din[31:16]} : {din[31:16], old[15:0]};
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Shared termination generator; the active select only sets its limit.
  ecs_wait_timer u_timer (
    .clk     (CLOCK),
    .rst_n   (RESET_N),
    .restart (restart),
    .run     (r.state == ecs_pkg::ECS_ACCESS),
    .limit   (r.waits),
    .expired (timer_expired)
  );

  assign bus_win = ecs_pkg::ecs_window(BUS_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n        = r;
    n.done   = 1'b0;
    n.err    = 1'b0;
    n.rd     = 16'h0000;
    hit      = 4'h0;
    sel_i    = 2'h0;
    addr_ok  = 1'b0;
    restart  = 1'b0;
    term_int = 1'b0;
    term     = 1'b0;

    // The boot straps are caught on the first clock after reset release, never by the reset itself.
    if (!r.boot_seen) begin
      n.boot_seen                        = 1'b1;
      n.ctrl[0][ecs_pkg::BIT_SEL_EN]     = STRAP_BOOT_EN;
      n.ctrl[0][ecs_pkg::BIT_PORT_WIDTH] = STRAP_BOOT_WIDE;
    end

    if (REG_WR) begin
      if (REG_ADDR == ecs_pkg::OFS_SEL0) begin
        n.ctrl[0] = REG_WDATA & ecs_pkg::CTRL_WMASK;
      end else if (REG_ADDR == ecs_pkg::OFS_SEL1) begin
        n.ctrl[1] = REG_WDATA & ecs_pkg::CTRL_WMASK;
      end else if (REG_ADDR == ecs_pkg::OFS_SEL2) begin
        n.ctrl[2] = REG_WDATA & ecs_pkg::CTRL_WMASK;
      end else if (REG_ADDR == ecs_pkg::OFS_SEL3) begin
        n.ctrl[3] = REG_WDATA & ecs_pkg::CTRL_WMASK;
      end
    end

    if (REG_RD) begin
      if (REG_ADDR == ecs_pkg::OFS_SEL0) begin
        n.rd = r.ctrl[0];
      end else if (REG_ADDR == ecs_pkg::OFS_SEL1) begin
        n.rd = r.ctrl[1];
      end else if (REG_ADDR == ecs_pkg::OFS_SEL2) begin
        n.rd = r.ctrl[2];
      end else if (REG_ADDR == ecs_pkg::OFS_SEL3) begin
        n.rd = r.ctrl[3];
      end else if (REG_ADDR == ecs_pkg::OFS_STATUS) begin
        n.rd = {11'h000, r.dual, r.lo, (r.state == ecs_pkg::ECS_ACCESS), r.sel};
      end
    end

    // Only A31 and A24..23 take part; A30..25 mirror the external block.
    for (int i = 0; i < 4; i++) begin
      addr_ok = BUS_ADDR[ecs_pkg::ADDR_EXT_BIT] && (bus_win == 2'(i));
      if (i == 1 && INTERNAL_MEM_EMULATION) begin
        addr_ok = !BUS_ADDR[ecs_pkg::ADDR_EXT_BIT] && (bus_win == 2'h0);
      end
      hit[i] = addr_ok && r.ctrl[i][ecs_pkg::BIT_SEL_EN]
               && !(r.ctrl[i][ecs_pkg::BIT_READ_ONLY] && !BUS_RNW)
               && !(r.ctrl[i][ecs_pkg::BIT_PRIV_ONLY] && !BUS_SUPERVISOR);
      if (hit[i]) begin
        sel_i = 2'(i);
      end
    end
    sel_ctrl   = r.ctrl[sel_i];
    start_ok   = (r.state == ecs_pkg::ECS_IDLE) && BUS_START && (|hit);
    single_cyc = sel_ctrl[ecs_pkg::BIT_PORT_WIDTH] || (BUS_SIZE != ecs_pkg::SZ_WORD);

    case (r.state)
      ecs_pkg::ECS_IDLE: begin
        if (start_ok) begin
          n.state     = ecs_pkg::ECS_ACCESS;
          n.sel       = sel_i;
          n.narrow    = !sel_ctrl[ecs_pkg::BIT_PORT_WIDTH];
          n.dual      = !single_cyc;
          n.lo        = single_cyc ? BUS_ADDR[ecs_pkg::HALF_ADDR_BIT] : 1'b0;
          n.write     = !BUS_RNW;
          n.int_ack   = sel_ctrl[ecs_pkg::BIT_INT_ACK];
          n.wr_strobe = sel_ctrl[ecs_pkg::BIT_STROBE_STYLE];
          n.waits     = {1'b0, sel_ctrl[ecs_pkg::BIT_WAIT_HI:ecs_pkg::BIT_WAIT_LO]}
                        + {3'h0, sel_ctrl[ecs_pkg::BIT_WRITE_EXTRA] && !BUS_RNW};
          n.be        = BUS_BE;
          n.wdata     = BUS_WDATA;
          n.cs_n      = ~(4'h1 << sel_i);
          n.addr      = BUS_ADDR;
          n.bs_n      = lane_strobes(BUS_BE, n.narrow, n.lo,
                                     !BUS_RNW || !sel_ctrl[ecs_pkg::BIT_STROBE_STYLE]);
          n.dout      = lane_data(BUS_WDATA, n.narrow, n.lo);
          n.doe_n     = BUS_RNW;
          restart     = 1'b1;
        end
      end
      ecs_pkg::ECS_ACCESS: begin
        // Without internal ack the wait field is never consulted and only the far side ends the cycle.
        term_int = r.int_ack && timer_expired;
        term     = term_int || !TRANSFER_ACK_N;
        if (!TRANSFER_ERROR_ACK_N) begin
          // An error aborts the whole access, including a pending second half.
          n.err   = 1'b1;
          n.state = ecs_pkg::ECS_IDLE;
          n.cs_n  = ecs_pkg::STROBE_IDLE;
          n.bs_n  = ecs_pkg::STROBE_IDLE;
          n.doe_n = 1'b1;
        end else if (term) begin
          if (!r.write) begin
            n.rdata = lane_capture(r.rdata, EXT_DATA_IN, r.narrow, r.lo);
          end
          if (r.dual && !r.lo) begin
            // Select stays asserted across both halves; only A1, lanes and strobes move.
            n.lo                         = 1'b1;
            n.addr[ecs_pkg::HALF_ADDR_BIT] = 1'b1;
            n.bs_n                       = lane_strobes(r.be, r.narrow, 1'b1, r.write || !r.wr_strobe);
            n.dout                       = lane_data(r.wdata, r.narrow, 1'b1);
            restart                      = 1'b1;
          end else begin
            n.done  = 1'b1;
            n.state = ecs_pkg::ECS_IDLE;
            n.cs_n  = ecs_pkg::STROBE_IDLE;
            n.bs_n  = ecs_pkg::STROBE_IDLE;
            n.doe_n = 1'b1;
          end
        end
      end
      default: begin
        n.state = ecs_pkg::ECS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      r       <= '0;
      r.state <= ecs_pkg::ECS_IDLE;
      r.ctrl  <= {4{ecs_pkg::CTRL_RESET}};
      r.cs_n  <= ecs_pkg::STROBE_IDLE;
      r.bs_n  <= ecs_pkg::STROBE_IDLE;
      r.doe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every output is a register field. The block has no request line to the interrupt controller.
  assign REG_RDATA     = r.rd;
  assign BUS_RDATA     = r.rdata;
  assign BUS_DONE      = r.done;
  assign BUS_ERR       = r.err;
  assign CS_N          = r.cs_n;
  assign BYTE_STROBE_N = r.bs_n;
  assign EXT_ADDR      = r.addr;
  assign EXT_DATA_OUT  = r.dout;
  assign EXT_DATA_OE_N = r.doe_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  logic       act;
  logic       acks_hi;
  logic       ext_raw;
  logic [4:0] cyc_r;

  assign act     = (r.state == ecs_pkg::ECS_ACCESS);
  assign acks_hi = TRANSFER_ACK_N && TRANSFER_ERROR_ACK_N;
  assign ext_raw = BUS_ADDR[ecs_pkg::ADDR_EXT_BIT] && !(INTERNAL_MEM_EMULATION && bus_win == 2'h1);

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      cyc_r <= 5'h00;
    end else begin
      cyc_r <= (restart || !act) ? 5'h00 : 5'(cyc_r + 5'h01);
    end
  end

  chk_ro_write_ignored: assert property (
    !act && BUS_START && !BUS_RNW && ext_raw && r.ctrl[bus_win][ecs_pkg::BIT_READ_ONLY] |=> CS_N == 4'hF)
    else $error("write reached a read-only window");

  chk_disabled_high: assert property (
    !act && BUS_START && ext_raw && !r.ctrl[bus_win][ecs_pkg::BIT_SEL_EN] |=> CS_N == 4'hF)
    else $error("disabled select asserted");

  chk_internal_quiet: assert property (
    !act && BUS_START && !BUS_ADDR[ecs_pkg::ADDR_EXT_BIT] && !INTERNAL_MEM_EMULATION |=> CS_N == 4'hF)
    else $error("internal access drove a select");

  chk_decode_map: assert property (
    start_ok |=> CS_N == ~(4'h1 << $past(sel_i)))
    else $error("wrong select for window");

  chk_emul_window: assert property (
    !act && BUS_START && INTERNAL_MEM_EMULATION && BUS_ADDR[ecs_pkg::ADDR_EXT_BIT] && bus_win == 2'h1
    |=> CS_N[1])
    else $error("select 1 answered its external window under emulation");

  chk_one_active: assert property (
    $onehot0(~CS_N))
    else $error("more than one select active");

  chk_zero_wait: assert property (
    start_ok && single_cyc && sel_ctrl[ecs_pkg::BIT_INT_ACK]
    && sel_ctrl[ecs_pkg::BIT_WAIT_HI:ecs_pkg::BIT_WAIT_LO] == 3'h0 && BUS_RNW
    |=> CS_N != 4'hF ##1 (BUS_DONE || BUS_ERR))
    else $error("zero-wait read not ended two clocks after start");

  chk_write_extra: assert property (
    start_ok && single_cyc && !BUS_RNW && sel_ctrl[ecs_pkg::BIT_INT_ACK]
    && sel_ctrl[ecs_pkg::BIT_WRITE_EXTRA] && sel_ctrl[ecs_pkg::BIT_WAIT_HI:ecs_pkg::BIT_WAIT_LO] == 3'h0
    ##1 acks_hi [*2] |-> !BUS_DONE ##1 BUS_DONE)
    else $error("extra write wait not exactly one clock");

  chk_wait_full: assert property (
    act && term_int |-> cyc_r == {1'b0, r.waits})
    else $error("internal termination at wrong wait count");

  chk_no_self_term: assert property (
    act && !r.int_ack && acks_hi |=> !BUS_DONE && CS_N != 4'hF)
    else $error("cycle ended without external ack");

  chk_error_early: assert property (
    act && !TRANSFER_ERROR_ACK_N |=> BUS_ERR && CS_N == 4'hF && !BUS_DONE)
    else $error("error input did not end the cycle");

  chk_split_word: assert property (
    act && r.dual && !r.lo && term && TRANSFER_ERROR_ACK_N
    |=> !BUS_DONE && CS_N != 4'hF && EXT_ADDR[ecs_pkg::HALF_ADDR_BIT])
    else $error("second half of split word missing");

  chk_strobe_style: assert property (
    act && r.wr_strobe && !r.write |-> BYTE_STROBE_N == 4'hF)
    else $error("strobes asserted on read in write-strobe mode");

  chk_idle_strobes: assert property (
    CS_N == 4'hF |-> BYTE_STROBE_N == 4'hF)
    else $error("strobes active with no select");

  chk_cs_hold: assert property (
    act && !term && TRANSFER_ERROR_ACK_N |=> CS_N != 4'hF)
    else $error("select dropped before termination");

  cov_split_read: cover property (start_ok && !single_cyc && BUS_RNW ##[1:40] BUS_DONE);
  cov_error_end:  cover property (act ##1 BUS_ERR);
  cov_ext_ack:    cover property (act && !r.int_ack && !TRANSFER_ACK_N ##1 BUS_DONE);
  cov_extra_wr:   cover property (start_ok && !BUS_RNW && sel_ctrl[ecs_pkg::BIT_WRITE_EXTRA]);

endmodule

// ### src/ecs_wait_timer.sv
module ecs_wait_timer (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       restart,
  input  wire logic                       run,
  input  wire logic [ecs_pkg::CNT_W-1:0]  limit,
  output logic                            expired
);

  typedef struct packed {
    logic [ecs_pkg::CNT_W-1:0] cnt;
  } ecs_timer_t;

  ecs_timer_t r;
  ecs_timer_t n;

  ////////////////////////////////////////////////////////////////////////////
  // One count per system clock; it parks at the limit until restarted.
  always_comb begin
    n = r;
    expired = run && (r.cnt == limit);
    if (restart) begin
      n.cnt = '0;
    end else if (run && !expired) begin
      n.cnt = r.cnt + ecs_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  chk_timer_bound: assert property (@(posedge clk) disable iff (!rst_n)
    run && !restart |-> r.cnt <= limit)
    else $error("wait counter ran past its limit");

endmodule

// ### tb/ecs_mem_model.sv
module ecs_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  cs_n,
  input  wire logic [31:0] addr,
  input  wire logic        data_oe_n,
  input  wire logic [3:0]  ack_at,
  input  wire logic [3:0]  err_at,
  output logic      [31:0] data_in,
  output logic             ack_n,
  output logic             err_n
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0]  cnt_r;
  logic [31:0] noise_r;
  logic        sel;

  assign sel = (cs_n != 4'hF);

  ////////////////////////////////////////////////////////////////////////////
  // A narrow device answers on the upper lanes, so the word pattern keeps a distinct upper half.
  // Outside a selected read the lines toggle every cycle, so a late capture cannot match by luck.
  assign data_in = (sel && data_oe_n) ? {addr[15:0] ^ 16'h5A3C, addr[15:0]} : noise_r;

  ////////////////////////////////////////////////////////////////////////////
  // An acknowledge set to cycle k of the select is driven low in that cycle only; zero means never.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r   <= 4'h0;
      noise_r <= 32'h0000_0000;
      ack_n   <= 1'b1;
      err_n   <= 1'b1;
    end else begin
      noise_r <= ~noise_r;
      cnt_r   <= sel ? cnt_r + 4'h1 : 4'h0;
      ack_n   <= !(sel && ack_at != 4'h0 && cnt_r + 4'h2 == ack_at);
      err_n   <= !(sel && err_at != 4'h0 && cnt_r + 4'h2 == err_at);
    end
  end
endmodule

// ### tb/ecs_top_tb.sv
module ecs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        CLOCK, RESET_N, REG_WR, REG_RD, STRAP_BOOT_EN, STRAP_BOOT_WIDE, INTERNAL_MEM_EMULATION;
  logic [4:0]  REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA, seed;
  logic        BUS_START, BUS_RNW, BUS_SUPERVISOR, BUS_DONE, BUS_ERR, EXT_DATA_OE_N;
  logic        TRANSFER_ACK_N, TRANSFER_ERROR_ACK_N;
  logic [1:0]  BUS_SIZE;
  logic [3:0]  BUS_BE, CS_N, BYTE_STROBE_N, ack_at, err_at;
  logic [31:0] BUS_ADDR, BUS_WDATA, BUS_RDATA, EXT_ADDR, EXT_DATA_OUT, EXT_DATA_IN;
  int          num_errors, checks;

  ecs_top dut (.CLOCK, .RESET_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .STRAP_BOOT_EN,
    .STRAP_BOOT_WIDE, .INTERNAL_MEM_EMULATION, .BUS_START, .BUS_ADDR, .BUS_RNW, .BUS_SIZE, .BUS_BE,
    .BUS_SUPERVISOR, .BUS_WDATA, .BUS_RDATA, .BUS_DONE, .BUS_ERR, .CS_N, .BYTE_STROBE_N, .EXT_ADDR,
    .EXT_DATA_OUT, .EXT_DATA_OE_N, .EXT_DATA_IN, .TRANSFER_ACK_N, .TRANSFER_ERROR_ACK_N);

  ecs_mem_model model (.clk(CLOCK), .rst_n(RESET_N), .cs_n(CS_N), .addr(EXT_ADDR), .data_oe_n(EXT_DATA_OE_N),
    .ack_at, .err_at, .data_in(EXT_DATA_IN), .ack_n(TRANSFER_ACK_N), .err_n(TRANSFER_ERROR_ACK_N));

  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] ctl(input logic priv, ro, pw, wex, ss, input logic [2:0] ws, input logic iack, en);
    return {priv, ro, pw, wex, ss, ws, 6'h00, iack, en};
  endfunction

  // Cycle index of the ending pulse, counting the first select cycle as one.
  function automatic int exp_lat(input logic [2:0] ws, input logic wex, rnw, split);
    int w;
    w = ws + (wex && !rnw);
    return split ? 2 * (w + 1) + 1 : w + 2;
  endfunction

  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return {a[15:0] ^ 16'h5A3C, a[15:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic rnd(output logic [15:0] r);
    seed = lfsr(seed);
    r = seed;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge CLOCK);
    REG_WR    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge CLOCK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLOCK);
    REG_RD   <= 1'b0;
    #1;
    d = REG_RDATA;
  endtask

  // A select pattern of all ones means the access must be ignored, so the fixed wait is expected to run out.
  task automatic access(input logic [31:0] a, input logic rnw, sup, input logic [31:0] wd, input logic [3:0] ecs,
      output int lat, output logic [31:0] rd, dout, output logic [3:0] stb, output logic oen);
    logic held;
    held = 1'b1;
    lat  = 0;
    @(posedge CLOCK);
    BUS_START      <= 1'b1;
    BUS_ADDR       <= a;
    BUS_RNW        <= rnw;
    BUS_SUPERVISOR <= sup;
    BUS_WDATA      <= wd;
    @(posedge CLOCK);
    BUS_START      <= 1'b0;
    #1;
    stb  = BYTE_STROBE_N;
    dout = EXT_DATA_OUT;
    oen  = EXT_DATA_OE_N;
    for (int i = 1; i <= 20 && lat == 0; i++) begin
      if (CS_N !== ecs) held = 1'b0;
      @(posedge CLOCK);
      #1;
      if (BUS_DONE === 1'b1 || BUS_ERR === 1'b1) lat = i + 1;
    end
    rd = BUS_RDATA;
    check(held, 1'b1);
    if (lat == 0 && ecs !== 4'hF) begin
      num_errors++;
      $display("[ERR] %0t ns: access never ended", $time);
      tally_and_finish();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] r, r2, v;
    logic [31:0] a, wd, rd, dout;
    logic [3:0]  stb;
    logic [2:0]  ws;
    logic [1:0]  win;
    logic        oen, rnw, wex, ss;
    int          lat;
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA, BUS_START, BUS_ADDR, BUS_RNW, BUS_WDATA} = '0;
    {BUS_SUPERVISOR, INTERNAL_MEM_EMULATION, ack_at, err_at} = '0;
    BUS_SIZE        = ecs_pkg::SZ_WORD;
    BUS_BE          = 4'hF;
    STRAP_BOOT_EN   = 1'b1;
    STRAP_BOOT_WIDE = 1'b0;
    RESET_N         = 1'b0;
    num_errors      = 0;
    checks          = 0;
    seed            = 16'hB57E;
    repeat (2) @(posedge CLOCK);
    RESET_N <= 1'b1;
    repeat (2) @(posedge CLOCK);

    for (int s = 0; s < 4; s++) begin
      reg_rd(5'(s * 4), v);
      check(v, s == 0 ? 16'h1F03 : ecs_pkg::CTRL_RESET);
    end
    reg_rd(5'h14, v);
    check(v, 16'h0000);
    rnd(r);
    reg_wr(ecs_pkg::OFS_SEL3, r);
    reg_rd(ecs_pkg::OFS_SEL3, v);
    check(v, r & ecs_pkg::CTRL_WMASK);
    $display("test registers done");

    // Boot select: narrow port, seven waits, strobes only on writes.
    access(32'h8000_0100, 1'b1, 1'b1, 32'h0, 4'hE, lat, rd, dout, stb, oen);
    check(lat, exp_lat(3'h7, 1'b1, 1'b1, 1'b1));
    check(rd, {16'h0100 ^ 16'h5A3C, 16'h0102 ^ 16'h5A3C});
    check(stb, 4'hF);
    $display("test boot done");

    for (int i = 0; i < 12; i++) begin
      rnd(r);
      rnd(r2);
      win = 2'(i);
      {ss, wex, ws, rnw} = r[5:0];
      if (i == 0) {ws, wex, rnw} = {3'h0, 1'b1, 1'b0};
      if (i == 1) {ws, wex, rnw} = {3'h7, 1'b1, 1'b0};
      if (i == 2) {ws, wex, rnw} = {3'h7, 1'b1, 1'b1};
      reg_wr(5'(i % 4 * 4), ctl(1'b0, 1'b0, 1'b1, wex, ss, ws, 1'b1, 1'b1));
      a  = {1'b1, r2[14:9], win, r2[8:0], r[15:4], 2'b00};
      wd = {r2, r};
      access(a, rnw, r2[15], wd, ~(4'h1 << win), lat, rd, dout, stb, oen);
      check(lat, exp_lat(ws, wex, rnw, 1'b0));
      check(stb, (ss && rnw) ? 4'hF : 4'h0);
      if (rnw) check(rd, mem_word(a));
      else begin
        check(dout, wd);
        check(oen, 1'b0);
      end
      check(BYTE_STROBE_N, 4'hF);
    end
    $display("test decode done");

    reg_wr(ecs_pkg::OFS_SEL2, ctl(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 1'b1, 1'b1));
    access(32'h8100_0000, 1'b0, 1'b1, 32'h1234_5678, 4'hF, lat, rd, dout, stb, oen);
    check(lat, 0);
    access(32'hFF00_0040, 1'b1, 1'b1, 32'h0, 4'hB, lat, rd, dout, stb, oen);
    check(lat, 2);
    access(32'h0100_0040, 1'b1, 1'b1, 32'h0, 4'hF, lat, rd, dout, stb, oen);
    check(lat, 0);
    reg_wr(ecs_pkg::OFS_SEL3, ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 1'b1, 1'b1));
    access(32'h8180_0000, 1'b1, 1'b0, 32'h0, 4'hF, lat, rd, dout, stb, oen);
    check(lat, 0);
    access(32'h8180_0000, 1'b1, 1'b1, 32'h0, 4'h7, lat, rd, dout, stb, oen);
    check(lat, 2);
    reg_wr(ecs_pkg::OFS_SEL3, ctl(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0));
    access(32'h8180_0000, 1'b1, 1'b1, 32'h0, 4'hF, lat, rd, dout, stb, oen);
    check(lat, 0);
    $display("test refusals done");

    reg_wr(ecs_pkg::OFS_SEL2, ctl(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 1'b1));
    ack_at <= 4'h4;
    access(32'h8100_0080, 1'b1, 1'b1, 32'h0, 4'hB, lat, rd, dout, stb, oen);
    check(lat, 5);
    check(rd, mem_word(32'h8100_0080));
    reg_wr(ecs_pkg::OFS_SEL2, ctl(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 3'h7, 1'b1, 1'b1));
    ack_at <= 4'h3;
    access(32'h8100_0000, 1'b0, 1'b1, 32'h0, 4'hB, lat, rd, dout, stb, oen);
    check(lat, 4);
    ack_at <= 4'h0;
    err_at <= 4'h2;
    access(32'h8100_0000, 1'b1, 1'b1, 32'h0, 4'hB, lat, rd, dout, stb, oen);
    check({lat[30:0], BUS_ERR}, {31'h3, 1'b1});
    err_at <= 4'h0;
    $display("test termination done");

    reg_wr(ecs_pkg::OFS_SEL1, ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1, 1'b1, 1'b1));
    access(32'h8080_0200, 1'b0, 1'b1, 32'hCAFE_F00D, 4'hD, lat, rd, dout, stb, oen);
    check(lat, exp_lat(3'h1, 1'b0, 1'b0, 1'b1));
    check(dout[31:16], 16'hCAFE);
    access(32'h8080_0200, 1'b1, 1'b1, 32'h0, 4'hD, lat, rd, dout, stb, oen);
    check(rd, {16'h0200 ^ 16'h5A3C, 16'h0202 ^ 16'h5A3C});
    // A half access to a narrow port stays one cycle; A1 picks the lower half onto the upper lanes.
    @(posedge CLOCK);
    BUS_SIZE <= 2'h1;
    BUS_BE   <= 4'h3;
    access(32'h8080_0202, 1'b0, 1'b1, 32'hCAFE_F00D, 4'hD, lat, rd, dout, stb, oen);
    check(lat, exp_lat(3'h1, 1'b0, 1'b0, 1'b0));
    check({dout[31:16], stb}, {16'hF00D, 4'h3});
    reg_wr(ecs_pkg::OFS_SEL1, ctl(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 1'b1, 1'b1));
    BUS_SIZE <= ecs_pkg::SZ_WORD;
    BUS_BE   <= 4'hF;
    INTERNAL_MEM_EMULATION <= 1'b1;
    access(32'h0012_3450, 1'b1, 1'b1, 32'h0, 4'hD, lat, rd, dout, stb, oen);
    check(lat, 2);
    access(32'h8080_0000, 1'b1, 1'b1, 32'h0, 4'hF, lat, rd, dout, stb, oen);
    check(lat, 0);
    INTERNAL_MEM_EMULATION <= 1'b0;
    $display("test split and emulation done");
    tally_and_finish();
  end
endmodule
